// file: src/seq_cfg_pkg.sv
// package for the four-step sequencer configuration block
// assumes an apb slave with 32-bit data and byte addresses
package seq_cfg_pkg;
    localparam logic [11:0] OFS_SEQ1_INPUT_SELECT = 12'h060;
    localparam logic [11:0] OFS_SEQ1_SAMPLE_CONTROL = 12'h064;
    localparam logic [11:0] OFS_SEQ2_INPUT_SELECT = 12'h080;
    localparam logic [11:0] OFS_SEQ2_SAMPLE_CONTROL = 12'h084;
    localparam logic [11:0] OFS_SEQ_RUN = 12'h0C0;
    localparam logic [11:0] OFS_SEQ_STATUS = 12'h0C4;
    localparam logic [31:0] INPUT_SELECT_MASK = 32'h0000_3333;
    localparam logic [31:0] SAMPLE_CONTROL_MASK = 32'h0000_FFFF;
    localparam logic [31:0] RESET_VALUE = 32'h0000_0000;
    localparam int SLOT_COUNT = 4;
    localparam int INPUT_FIELD_STRIDE = 4;
    localparam int FLAG_FIELD_STRIDE = 4;
    localparam int FLAG_DIFF = 0;
    localparam int FLAG_LAST = 1;
    localparam int FLAG_IRQ = 2;
    localparam int FLAG_TEMP = 3;
    localparam int RUN_SEQ1_BIT = 0;
    localparam int RUN_SEQ2_BIT = 1;

    typedef struct packed {
        logic [1:0] inputSel;
        logic tempSel;
        logic irqEnable;
        logic lastFlag;
        logic differential;
    } slot_cfg_t;

    typedef struct packed {
        logic valid;
        logic [0:0] seqId;
        logic [1:0] slot;
        logic [1:0] inputSel;
        logic tempSel;
        logic differential;
    } sample_req_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_STEP = 3'b010,
        ST_DONE = 3'b100
    } seq_state_t;
endpackage

// file: src/four_step_sequencer_config.sv
// four-step sequencer configuration registers and the stepping engine
// assumes an apb master on core_clk; a converter accepts one sample per sampleAck
// Operation
// RQ1 - each sequencer has an input-select register with four slot choices
// RQ2 - fourth slot input at 13:12, third at 9:8, writable, reset zero
// RQ3 - second slot input at 5:4, first at 1:0, writable, reset zero
// RQ4 - input-select bits 31:14, 11:10, 7:6, 3:2 read zero, writes ignored
// RQ5 - each sequencer has a control register of four flag nibbles, upper reserved
// RQ6 - fourth slot flags at 15:12, third at 11:8: temp, irq, last, diff
// RQ7 - second slot flags: temp 7, irq 6, last 5, diff 4; reset zero
// RQ8 - first slot flags: temp 3, irq 2, last 1, diff 0; reset zero
// RQ9 - software marks at least one slot as end of sequence
// RQ10 - engine steps slots in order, uses temp sensor, stops at last, pulses irq
//
// Register access over APB was decided locally.
`timescale 1ns/10ps
module four_step_sequencer_config (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic sampleAck,
    output seq_cfg_pkg::sample_req_t sampleReq,
    output logic sampleIrq,
    output logic seqDone
);

    ////////////////////////////////////////////////////////////////////////
    // register storage

    logic [31:0] inSel1_reg, inSel1_next;
    logic [31:0] ctl1_reg, ctl1_next;
    logic [31:0] inSel2_reg, inSel2_next;
    logic [31:0] ctl2_reg, ctl2_next;
    logic [31:0] prdata_reg, prdata_next;
    logic pslverr_reg, pslverr_next;
    logic pready_reg, pready_next;

    seq_cfg_pkg::seq_state_t state_reg, state_next;
    logic [0:0] seqId_reg, seqId_next;
    logic [1:0] slot_reg, slot_next;
    logic pending1_reg, pending1_next;
    logic pending2_reg, pending2_next;
    seq_cfg_pkg::sample_req_t req_reg, req_next;
    logic irq_reg, irq_next;
    logic done_reg, done_next;

    logic apbAccess;
    logic apbWrite;
    seq_cfg_pkg::slot_cfg_t curSlot;

    // picks one slot's settings out of a sequencer's register pair
    function automatic seq_cfg_pkg::slot_cfg_t slotDecode(
        input logic [31:0] muxWord,
        input logic [31:0] ctlWord,
        input logic [1:0] slot
    );
        seq_cfg_pkg::slot_cfg_t cfg;
        logic [31:0] muxShift;
        logic [31:0] ctlShift;
        muxShift = muxWord >> (32'(slot) * seq_cfg_pkg::INPUT_FIELD_STRIDE);
        ctlShift = ctlWord >> (32'(slot) * seq_cfg_pkg::FLAG_FIELD_STRIDE);
        cfg.inputSel = muxShift[1:0];
        cfg.tempSel = ctlShift[seq_cfg_pkg::FLAG_TEMP];
        cfg.irqEnable = ctlShift[seq_cfg_pkg::FLAG_IRQ];
        cfg.lastFlag = ctlShift[seq_cfg_pkg::FLAG_LAST];
        cfg.differential = ctlShift[seq_cfg_pkg::FLAG_DIFF];
        return cfg;
    endfunction

    assign apbAccess = psel && penable && pready_reg;
    assign apbWrite = apbAccess && pwrite;
    assign curSlot = (seqId_reg == 1'b0) ? slotDecode(inSel1_reg, ctl1_reg, slot_reg)
                                         : slotDecode(inSel2_reg, ctl2_reg, slot_reg);

    ////////////////////////////////////////////////////////////////////////
    // apb slave: one wait state, pready high in the second access cycle

    always_comb begin
        inSel1_next = inSel1_reg;
        ctl1_next = ctl1_reg;
        inSel2_next = inSel2_reg;
        ctl2_next = ctl2_reg;
        prdata_next = prdata_reg;
        pslverr_next = 1'b0;
        pready_next = psel && penable && !pready_reg;
        if (psel && penable && !pready_reg) begin
            prdata_next = 32'h0000_0000;
            unique case (paddr)
                seq_cfg_pkg::OFS_SEQ1_INPUT_SELECT: begin
                    prdata_next = inSel1_reg; // see RQ1
                end
                seq_cfg_pkg::OFS_SEQ1_SAMPLE_CONTROL: begin
                    prdata_next = ctl1_reg; // see RQ5
                end
                seq_cfg_pkg::OFS_SEQ2_INPUT_SELECT: begin
                    prdata_next = inSel2_reg; // see RQ1
                end
                seq_cfg_pkg::OFS_SEQ2_SAMPLE_CONTROL: begin
                    prdata_next = ctl2_reg; // see RQ5
                end
                seq_cfg_pkg::OFS_SEQ_RUN: begin
                    prdata_next = {30'h0000_0000, pending2_reg, pending1_reg};
                end
                seq_cfg_pkg::OFS_SEQ_STATUS: begin
                    prdata_next = {27'h000_0000, seqId_reg, slot_reg,
                                   state_reg == seq_cfg_pkg::ST_STEP, done_reg};
                end
                default: begin
                    pslverr_next = 1'b1;
                end
            endcase
        end
        if (apbWrite) begin
            unique case (paddr)
                seq_cfg_pkg::OFS_SEQ1_INPUT_SELECT: begin
                    inSel1_next = pwdata & seq_cfg_pkg::INPUT_SELECT_MASK; // see RQ2 RQ3 RQ4
                end
                seq_cfg_pkg::OFS_SEQ1_SAMPLE_CONTROL: begin
                    ctl1_next = pwdata & seq_cfg_pkg::SAMPLE_CONTROL_MASK; // see RQ6 RQ7 RQ8
                end
                seq_cfg_pkg::OFS_SEQ2_INPUT_SELECT: begin
                    inSel2_next = pwdata & seq_cfg_pkg::INPUT_SELECT_MASK; // see RQ2 RQ3 RQ4
                end
                seq_cfg_pkg::OFS_SEQ2_SAMPLE_CONTROL: begin
                    ctl2_next = pwdata & seq_cfg_pkg::SAMPLE_CONTROL_MASK; // see RQ6 RQ7 RQ8
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            inSel1_reg <= seq_cfg_pkg::RESET_VALUE;
            ctl1_reg <= seq_cfg_pkg::RESET_VALUE;
            inSel2_reg <= seq_cfg_pkg::RESET_VALUE;
            ctl2_reg <= seq_cfg_pkg::RESET_VALUE;
            prdata_reg <= 32'h0000_0000;
            pslverr_reg <= 1'b0;
            pready_reg <= 1'b0;
        end else begin
            inSel1_reg <= inSel1_next;
            ctl1_reg <= ctl1_next;
            inSel2_reg <= inSel2_next;
            ctl2_reg <= ctl2_next;
            prdata_reg <= prdata_next;
            pslverr_reg <= pslverr_next;
            pready_reg <= pready_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sequencer engine: sequencer 1 is served before sequencer 2 when both are pending in idle

    always_comb begin
        state_next = state_reg;
        seqId_next = seqId_reg;
        slot_next = slot_reg;
        pending1_next = pending1_reg;
        pending2_next = pending2_reg;
        req_next = req_reg;
        irq_next = 1'b0;
        done_next = 1'b0;
        unique case (state_reg)
            seq_cfg_pkg::ST_IDLE: begin
                if (pending1_reg || pending2_reg) begin
                    seqId_next = pending1_reg ? 1'b0 : 1'b1;
                    slot_next = 2'h0; // see RQ10
                    state_next = seq_cfg_pkg::ST_STEP;
                end
            end
            seq_cfg_pkg::ST_STEP: begin
                if (!req_reg.valid) begin
                    req_next.valid = 1'b1;
                    req_next.seqId = seqId_reg;
                    req_next.slot = slot_reg;
                    req_next.inputSel = curSlot.inputSel; // see RQ10
                    req_next.tempSel = curSlot.tempSel; // see RQ10
                    req_next.differential = curSlot.differential;
                end else if (sampleAck) begin
                    req_next.valid = 1'b0;
                    irq_next = curSlot.irqEnable; // see RQ10
                    if (curSlot.lastFlag || slot_reg == 2'h3) begin // see RQ9 RQ10
                        state_next = seq_cfg_pkg::ST_DONE;
                    end else begin
                        slot_next = slot_reg + 2'h1;
                    end
                end
            end
            seq_cfg_pkg::ST_DONE: begin
                done_next = 1'b1;
                if (seqId_reg == 1'b0) begin
                    pending1_next = 1'b0;
                end else begin
                    pending2_next = 1'b0;
                end
                state_next = seq_cfg_pkg::ST_IDLE;
            end
        endcase
        // a start write wins over the completion clear
        if (apbWrite && paddr == seq_cfg_pkg::OFS_SEQ_RUN) begin
            if (pwdata[seq_cfg_pkg::RUN_SEQ1_BIT]) begin
                pending1_next = 1'b1;
            end
            if (pwdata[seq_cfg_pkg::RUN_SEQ2_BIT]) begin
                pending2_next = 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            state_reg <= seq_cfg_pkg::ST_IDLE;
            seqId_reg <= 1'b0;
            slot_reg <= 2'h0;
            pending1_reg <= 1'b0;
            pending2_reg <= 1'b0;
            req_reg <= '0;
            irq_reg <= 1'b0;
            done_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            seqId_reg <= seqId_next;
            slot_reg <= slot_next;
            pending1_reg <= pending1_next;
            pending2_reg <= pending2_next;
            req_reg <= req_next;
            irq_reg <= irq_next;
            done_reg <= done_next;
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign sampleReq = req_reg;
    assign sampleIrq = irq_reg;
    assign seqDone = done_reg;

endmodule // four_step_sequencer_config

// file: test/seq_cfg_sva.sv
// port assertions for the sequencer configuration block
// bound to four_step_sequencer_config from tb_top; one clock, async reset
`timescale 1ns/10ps
module seq_cfg_sva (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic sampleAck,
    input wire seq_cfg_pkg::sample_req_t sampleReq,
    input wire logic sampleIrq,
    input wire logic seqDone
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);
    logic rdMux;
    logic rdCtl;
    logic mapped;
    assign rdMux = pready && !pwrite && paddr inside {12'h060, 12'h080};
    assign rdCtl = pready && !pwrite && paddr inside {12'h064, 12'h084};
    assign mapped = paddr inside {12'h060, 12'h064, 12'h080, 12'h084, 12'h0C0, 12'h0C4};
    sequence apbWait;
        psel && penable && !pready;
    endsequence
    sequence apbAnswer;
        psel && penable && pready;
    endsequence
    ////////////////////////////////////////////////////////////////////////////////
    AST_APB_WAIT:
        assert property (psel && $rose(penable) |-> apbWait ##1 apbAnswer)
        else $error("apb answer not after one wait state");
    AST_READY_PULSE:
        assert property (pready |=> !pready) else $error("pready longer than one cycle");
    AST_UNMAPPED:
        assert property (pready |-> pslverr == !mapped) else $error("pslverr wrong for address");
    AST_MUX_RESERVED:
        assert property (rdMux |-> (prdata & 32'hFFFF_CCCC) == 32'h0)
        else $error("input select reserved bits not zero");
    AST_CTL_RESERVED:
        assert property (rdCtl |-> prdata[31:16] == 16'h0) else $error("control upper bits set");
    AST_REQ_HOLD:
        assert property (sampleReq.valid && !sampleAck |=> $stable(sampleReq))
        else $error("request changed before ack");
    AST_REQ_DROP:
        assert property (sampleReq.valid && sampleAck |=> !sampleReq.valid)
        else $error("request still valid after ack");
    AST_IRQ_CAUSE:
        assert property (sampleIrq |-> $past(sampleAck && sampleReq.valid, 1)
            || $past(sampleAck && sampleReq.valid, 2)) else $error("irq without acked slot");
    AST_DONE_PULSE:
        assert property (seqDone |=> !seqDone) else $error("done longer than one cycle");
endmodule // seq_cfg_sva

// file: test/converter_model.sv
// converter model on the far side of the sample link
// acks each request ackDelay+1 cycles after it appears, with a one-cycle pulse
`timescale 1ns/10ps
module converter_model (
    input wire logic core_clk,
    input wire logic nrst,
    input wire seq_cfg_pkg::sample_req_t sampleReq,
    input wire logic [3:0] ackDelay,
    output logic sampleAck
);
    logic [3:0] waitCnt;
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            waitCnt <= 4'h0;
            sampleAck <= 1'b0;
        end else if (sampleAck || !sampleReq.valid) begin
            waitCnt <= 4'h0;
            sampleAck <= 1'b0;
        end else if (waitCnt >= ackDelay) begin
            sampleAck <= 1'b1;
        end else begin
            waitCnt <= waitCnt + 4'h1;
        end
    end
endmodule // converter_model

// file: test/tb_top.sv
// self-checking bench for the sequencer configuration block
// apb master tasks; converter_model answers the sample link
`timescale 1ns/10ps
module tb_top;
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic sampleAck;
    logic sampleIrq;
    logic seqDone;
    logic [3:0] ackDelay = 4'h3;
    logic [31:0] rdata;
    logic rerr;
    seq_cfg_pkg::sample_req_t sampleReq;
    seq_cfg_pkg::sample_req_t gotQ[$];
    logic [31:0] expQ[$];
    logic [11:0] regs [4] = '{12'h060, 12'h064, 12'h080, 12'h084};
    logic [31:0] full [4] = '{32'h0000_3333, 32'h0000_FFFF, 32'h0000_3333, 32'h0000_FFFF};
    int badCount = 0;
    int checkCount = 0;
    int irqCount = 0;
    int doneCount = 0;
    always #2 core_clk = ~core_clk;
    four_step_sequencer_config four_step_sequencer_config_inst (.core_clk(core_clk), .nrst(nrst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .sampleAck(sampleAck),
        .sampleReq(sampleReq), .sampleIrq(sampleIrq), .seqDone(seqDone));
    converter_model converter_model_inst (.core_clk(core_clk), .nrst(nrst),
        .sampleReq(sampleReq), .ackDelay(ackDelay), .sampleAck(sampleAck));
    always @(posedge core_clk) begin
        if (sampleReq.valid === 1'b1 && sampleAck === 1'b1) begin
            gotQ.push_back(sampleReq);
        end
        irqCount += int'(sampleIrq === 1'b1);
        doneCount += int'(seqDone === 1'b1);
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checkCount++;
        if (seen !== exp) begin
            badCount++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1) @(posedge core_clk);
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] e, input logic eErr);
        apb(1'b0, a, 32'h0);
        check(rdata, e);
        check({31'h0, rerr}, {31'h0, eErr});
    endtask
    function automatic logic [31:0] req(logic s, logic [1:0] sl, logic [1:0] n, logic t, logic d);
        return {24'h0, 1'b1, s, sl, n, t, d};
    endfunction
    task automatic expectRun(input int doneWant, input int irqWant);
        for (int i = 0; i < 400 && doneCount < doneWant; i++) @(posedge core_clk);
        repeat (3) @(posedge core_clk);
        check(32'(doneCount), 32'(doneWant));
        check(32'(irqCount), 32'(irqWant));
        check(32'(gotQ.size()), 32'(expQ.size()));
        foreach (expQ[k]) check({24'h0, gotQ[k]}, expQ[k]);
        gotQ.delete();
        expQ.delete();
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", checkCount, badCount);
        if (badCount == 0 && checkCount > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (2) @(posedge core_clk);
        nrst <= 1'b1;
        foreach (regs[i]) rdc(regs[i], 32'h0, 1'b0);
        foreach (regs[i]) begin
            apb(1'b1, regs[i], 32'hFFFF_FFFF);
            rdc(regs[i], full[i], 1'b0);
        end
        rdc(12'h070, 32'h0, 1'b1);
        apb(1'b1, 12'h060, 32'h0000_0321);
        apb(1'b1, 12'h064, 32'h0000_061C);
        apb(1'b1, 12'h080, 32'h0000_3210);
        apb(1'b1, 12'h084, 32'h0000_6000);
        expQ = '{req(0, 0, 1, 1, 0), req(0, 1, 2, 0, 1), req(0, 2, 3, 0, 0), req(1, 0, 0, 0, 0),
            req(1, 1, 1, 0, 0), req(1, 2, 2, 0, 0), req(1, 3, 3, 0, 0)};
        apb(1'b1, 12'h0C0, 32'h0000_0003);
        expectRun(2, 3);
        ackDelay <= 4'h0;
        apb(1'b1, 12'h064, 32'h0000_0003);
        expQ = '{req(0, 0, 1, 0, 1)};
        apb(1'b1, 12'h0C0, 32'h0000_0001);
        expectRun(3, 3);
        summarize();
    end
    initial begin
        repeat (4000) @(posedge core_clk);
        badCount++;
        summarize();
    end
endmodule // tb_top

bind four_step_sequencer_config seq_cfg_sva seq_cfg_sva_inst (.core_clk(core_clk), .nrst(nrst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .sampleAck(sampleAck),
    .sampleReq(sampleReq), .sampleIrq(sampleIrq), .seqDone(seqDone));
